// *** rtl/relay_port.sv ***
// Purpose: isolated input / relay output port with per-input filters over APB
// Assumes: single 200 MHz clock, asynchronous active-high reset
// Notes: zero wait states; pready high except in reset, pslverr never set
//
// Summary of operation
// - two byte ports drive sixteen relays
// - relay port reads return relay state
// - sixteen inputs read as two bytes
// - each input has switchable 5 ms filter
// - filter enable held per channel
// - reset clears every filter enable
// - eight-address window, six ports functional
// - each port bit maps one channel
// - zero bit de-energises relay, break contact
// - one bit energises relay, make contact
// - inputs follow in 20 us or 5 ms
// - filter ports at 3 and 6, read zero
// - filter bit one enables, zero disables
`timescale 1ns/1ps
`default_nettype none
module relay_port
  import relay_port_pkg::*;
#(
  parameter int filter_count = filter_cycles,
  parameter int raw_count = raw_cycles
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] input_pins,
  output logic [15:0] relay_output_bits
);

  apb_req_s req;
  logic [7:0] relay_lo_r;
  logic [7:0] relay_hi_r;
  logic [7:0] filter_lo_r;
  logic [7:0] filter_hi_r;
  logic [15:0] in_sync;
  logic [15:0] in_state;

  // bundle the bus request
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // address decode within the window
  wire [2:0] idx = req.addr[addr_lsb +: 3];
  wire in_window = req.addr[31:window_bits] == '0;
  wire access = req.sel && req.enable && in_window;
  wire wr = access && req.write && pstrb[0];
  // reads decode in the setup phase so the data already stands at the completing edge
  wire rd = req.sel && !req.enable && !req.write && in_window;
  wire wr_relay_lo = wr && idx == idx_relay_lo;
  wire wr_relay_hi = wr && idx == idx_relay_hi;
  wire wr_filt_lo = wr && idx == idx_filter_lo;
  wire wr_filt_hi = wr && idx == idx_filter_hi;

  // read multiplexer; filter ports and unused slots read zero
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      idx_relay_lo: rd_byte = relay_lo_r;
      idx_relay_hi: rd_byte = relay_hi_r;
      idx_input_lo: rd_byte = in_state[7:0];
      idx_input_hi: rd_byte = in_state[15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  // relay control registers, cleared on reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      relay_lo_r <= relay_reset;
      relay_hi_r <= relay_reset;
    end else begin
      if (wr_relay_lo) relay_lo_r <= req.wdata[7:0];
      if (wr_relay_hi) relay_hi_r <= req.wdata[7:0];
    end
  end

  // filter enables, one bit per input
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filter_lo_r <= filter_reset;
      filter_hi_r <= filter_reset;
    end else begin
      if (wr_filt_lo) filter_lo_r <= req.wdata[7:0];
      if (wr_filt_hi) filter_hi_r <= req.wdata[7:0];
    end
  end

  // relay drive: a one energises, a zero releases
  always_ff @(posedge clk or posedge reset) begin
    if (reset) relay_output_bits <= {2{relay_reset}};
    else relay_output_bits <= {relay_hi_r, relay_lo_r};
  end

  // apb response registers; read data loads at the end of setup
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // pin synchroniser
  input_sync #(.width(16)) u_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(input_pins),
    .pin_sync(in_sync)
  );

  // one filter per input channel
  wire [15:0] filt_en = {filter_hi_r, filter_lo_r};
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_chan
      input_filter #(.long_count(filter_count), .short_count(raw_count)) u_filt (
        .clk(clk),
        .reset(reset),
        .in_sync(in_sync[g]),
        .filter_on(filt_en[g]),
        .state(in_state[g])
      );
    end
  endgenerate

endmodule : relay_port
`default_nettype wire

// *** rtl/relay_port_pkg.sv ***
// Purpose: shared constants and types for the isolated input / relay output port
// Assumes: 200 MHz clock, byte-wide ports in an eight-address window over APB
// Notes: each byte port takes one aligned 32-bit word (byte address = index * 4)
package relay_port_pkg;

  // port indices within the eight-address window
  localparam logic [2:0] idx_relay_lo = 3'h0;
  localparam logic [2:0] idx_relay_hi = 3'h1;
  localparam logic [2:0] idx_input_lo = 3'h2;
  localparam logic [2:0] idx_filter_lo = 3'h3;
  localparam logic [2:0] idx_input_hi = 3'h5;
  localparam logic [2:0] idx_filter_hi = 3'h6;
  localparam int addr_lsb = 2;
  localparam int window_bits = 5;

  // reset values
  localparam logic [7:0] relay_reset = 8'h00;
  localparam logic [7:0] filter_reset = 8'h00;

  // timing
  localparam int clk_mhz = 200;
  localparam int filter_ms = 5;
  localparam int raw_us = 20;
  localparam int filter_cycles = filter_ms * 1000 * clk_mhz;
  localparam int raw_cycles = raw_us * clk_mhz;

  // apb request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } apb_req_s;

endpackage : relay_port_pkg

// *** rtl/input_sync.sv ***
// Purpose: two-flop synchroniser for a group of asynchronous input pins
// Assumes: pins are quiet relative to the clock only in the statistical sense
// Notes: the first stage feeds nothing but the second stage
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int width = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] pin_sync
);

  logic [width-1:0] meta_r;

  // two stages, reset to low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      pin_sync <= '0;
    end else begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end

endmodule : input_sync
`default_nettype wire

// *** rtl/input_filter.sv ***
// Purpose: one input channel with a switchable low-pass stage
// Assumes: input already synchronised; tick-free counters on the system clock
// Notes: unfiltered path is a short stability check, filtered path a long one
`timescale 1ns/1ps
`default_nettype none
module input_filter #(
  parameter int long_count = 1000000,
  parameter int short_count = 4000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_sync,
  input wire logic filter_on,
  output logic state
);

  localparam int cw = $clog2(long_count + 1);
  localparam logic [cw-1:0] long_lim = cw'(long_count - 1);
  localparam logic [cw-1:0] short_lim = cw'(short_count - 1);

  logic [cw-1:0] count_r;
  wire differs = in_sync != state;
  wire [cw-1:0] limit = filter_on ? long_lim : short_lim;
  wire done = count_r >= limit;

  // output follows input once it has differed for the chosen time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_r <= '0;
      state <= 1'b0;
    end else if (!differs) begin
      count_r <= '0;
    end else if (done) begin
      count_r <= '0;
      state <= in_sync;
    end else begin
      count_r <= count_r + cw'(1);
    end
  end

endmodule : input_filter
`default_nettype wire

// *** test/relay_port_checker.sv ***
// Purpose: port-level checks of relay_port
// Assumes: zero wait apb, read data standing at the completing edge, relays two edges after a write
// Notes: attached by bind
`timescale 1ns/1ps
`default_nettype none
module relay_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] relay_output_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // decoded transfer kinds
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite && pstrb[0];
  wire rd = acc && !pwrite;
  property p_lo; wr && paddr == 32'h0 |=> ##1 relay_output_bits[7:0] == $past(pwdata[7:0], 2); endproperty
  a_lo: assert property (p_lo) else $error("relay low byte not written");
  property p_hi; wr && paddr == 32'h4 |=> ##1 relay_output_bits[15:8] == $past(pwdata[7:0], 2); endproperty
  a_hi: assert property (p_hi) else $error("relay high byte not written");
  property p_hold; !(wr && paddr[31:3] == 29'h0) |-> ##2 $stable(relay_output_bits); endproperty
  a_hold: assert property (p_hold) else $error("relay changed without write");
  property p_rback; rd && paddr == 32'h0 |-> prdata == {24'h0, relay_output_bits[7:0]}; endproperty
  a_rback: assert property (p_rback) else $error("relay readback wrong");
  property p_filt; rd && (paddr == 32'hc || paddr == 32'h18) |-> prdata == 32'h0; endproperty
  a_filt: assert property (p_filt) else $error("filter port read not zero");
  property p_unused; rd && (paddr == 32'h10 || paddr == 32'h1c || paddr[31:5] != 27'h0) |-> prdata == 32'h0; endproperty
  a_unused: assert property (p_unused) else $error("unused read not zero");
  property p_rst; disable iff (1'b0) reset |-> relay_output_bits == 16'h0 && !pready; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_err; acc |-> !pslverr; endproperty
  a_err: assert property (p_err) else $error("slave error seen");
endmodule : relay_port_checker
bind relay_port relay_port_checker i_relay_port_checker (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .relay_output_bits(relay_output_bits));
`default_nettype wire

// *** test/field_side.sv ***
// Purpose: field wiring model, pins follow commanded levels
// Assumes: opto inputs always driven
// Notes: relay drive only observed
`timescale 1ns/1ps
`default_nettype none
module field_side (
  input wire logic [15:0] level,
  output logic [15:0] pins
);
  assign pins = level;
endmodule : field_side
`default_nettype wire

// *** test/isolated_input_relay_output_port_test.sv ***
// Purpose: self-checking bench for relay_port
// Assumes: filter_count 20, raw_count 4
// Notes: apb master tasks, read data taken at the completing edge
`timescale 1ns/1ps
`default_nettype none
module isolated_input_relay_output_port_test;
  import relay_port_pkg::*;
  logic clk = 0, reset, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, q;
  logic [3:0] pstrb = 4'hf;
  logic [15:0] level = 0, pins, relay_output_bits;
  int bad_count = 0, total_checks = 0;
  relay_port #(.filter_count(20), .raw_count(4)) i_relay_port (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_pins(pins), .relay_output_bits(relay_output_bits));
  field_side i_field_side (.level(level), .pins(pins));
  initial forever #2.5 clk = ~clk;
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // read data is taken at the edge that completes the access
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end else begin
      @(posedge clk);
    end
  endtask : xfer
  task rd(input logic [31:0] a, input logic [7:0] e);
    xfer(0, a, 32'h0);
    chk("prdata", {24'h0, e}, q);
  endtask : rd
  initial begin
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("relays", 16'h0, relay_output_bits);
    rd(32'h0, 8'h00);
    $display("reset test done");
    xfer(1, 32'h0, 32'hffa5);
    xfer(1, 32'h4, 32'h3c);
    // relay drive follows the control register one edge later
    @(posedge clk);
    chk("relays", 16'h3ca5, relay_output_bits);
    rd(32'h0, 8'ha5);
    rd(32'h4, 8'h3c);
    pstrb <= 4'h0;
    xfer(1, 32'h0, 32'h0);
    pstrb <= 4'hf;
    xfer(1, 32'h10, 32'hff);
    xfer(1, 32'h1c, 32'hff);
    xfer(1, 32'h20, 32'hff);
    @(posedge clk);
    chk("relays", 16'h3ca5, relay_output_bits);
    rd(32'h10, 8'h0);
    rd(32'h1c, 8'h0);
    rd(32'h20, 8'h0);
    rd(32'hc, 8'h0);
    rd(32'h18, 8'h0);
    $display("relay test done");
    level <= 16'h5a81;
    repeat (10) @(posedge clk);
    rd(32'h8, 8'h81);
    rd(32'h14, 8'h5a);
    xfer(1, 32'hc, 32'h01);
    level <= 16'h5a82;
    repeat (10) @(posedge clk);
    rd(32'h8, 8'h83);
    repeat (30) @(posedge clk);
    rd(32'h8, 8'h82);
    rd(32'hc, 8'h0);
    // high filter port: channel 9 filtered, channel 8 not
    xfer(1, 32'h18, 32'h02);
    level <= 16'h5982;
    repeat (10) @(posedge clk);
    rd(32'h14, 8'h5b);
    repeat (30) @(posedge clk);
    rd(32'h14, 8'h59);
    rd(32'h18, 8'h0);
    xfer(1, 32'hc, 32'h00);
    xfer(1, 32'h18, 32'h00);
    level <= 16'h5a81;
    repeat (10) @(posedge clk);
    rd(32'h8, 8'h81);
    rd(32'h14, 8'h5a);
    $display("input test done");
    // reset in mid-run must drop relays and the low filter port enables
    xfer(1, 32'h0, 32'h7e);
    xfer(1, 32'hc, 32'hff);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("relays", 16'h0, relay_output_bits);
    repeat (10) @(posedge clk);
    rd(32'h8, 8'h81);
    rd(32'h0, 8'h00);
    $display("second reset test done");
    wrap_up();
  end
endmodule : isolated_input_relay_output_port_test
`default_nettype wire
